// file: rtl/pwm_gate_pkg.sv
// Shared constants for the PWM generator and the universal edge counter.
// Assumes a single 250 MHz driving clock and a synchronous active-low reset.
package pwm_gate_pkg;

	// Driving clock.
	localparam int SYS_CLK_MHZ = 250;

	// PWM reference divider: the reference tick is the driving clock divided by 512.
	localparam int REF_DIV_W = 9;
	localparam logic [REF_DIV_W-1:0] REF_DIV_LAST = 9'h1FF;

	// PWM period of 64 reference clocks, six-bit power value.
	localparam int PWM_PHASE_W = 6;
	localparam logic [PWM_PHASE_W-1:0] PWM_PHASE_LAST = 6'h3F;
	localparam logic [PWM_PHASE_W-1:0] POWER_RESET = 6'h00;

	// Gate divider width and default division exponents (2^22 and 2^26).
	localparam int GATE_DIV_W = 26;
	localparam int GATE1_DIV_LOG2 = 22;
	localparam int GATE2_DIV_LOG2 = 26;

	// Universal counter width and its reset value.
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

	// Width of the link terminals and pin banks.
	localparam int LINK_W = 16;

	// Positions inside the synchronised pin vector.
	localparam int SP_PIN0 = 0;
	localparam int SP_IOSEL = 16;
	localparam int SP_CTL_A = 19;
	localparam int SP_CTL_B = 20;
	localparam int SP_CHAIN = 21;
	localparam int SP_SECOND_STROBE_OUT = 22;
	localparam int SYNC_W = 23;

	// Pin positions within the pin bank.
	localparam int PIN_COUNT_IN = 4;
	localparam int PIN_GATE = 5;
	localparam int PIN_MODE0 = 6;
	localparam int PIN_MODE1 = 7;

	// Link terminal positions for power and run requests and the aux pass-through.
	localparam int LO_POWER_LSB = 0;
	localparam int LO_FWD_RUN = 6;
	localparam int LO_REV_RUN = 7;
	localparam int LO_AUX_LSB = 8;

	// Counting modes chosen by the two mode pins.
	typedef enum logic [1:0] {
		CM_FREE,
		CM_GATE1,
		CM_GATE2,
		CM_EXT_GATE
	} count_mode_t;

endpackage

// file: rtl/pin_sync3.sv
// Three-stage synchroniser bank for asynchronous pin inputs.
// Assumes one clock; a bit's output changes only once stages two and three agree.
`timescale 1ns/1ps

module pin_sync3 #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Asynchronous inputs and their settled copy.
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;

	// Shift chain; the first stage feeds only the second.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			stage1_q <= '0;
			stage2_q <= '0;
			stage3_q <= '0;
		end
		else
		begin
			stage1_q <= i_async;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
		end
	end

	// Accept a new level per bit only when the last two stages agree.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			o_sync <= '0;
		else
		begin
			for (int i = 0; i < WIDTH; i++)
			begin
				if (stage2_q[i] == stage3_q[i])
					o_sync[i] <= stage3_q[i];
			end
		end
	end

endmodule

// file: rtl/pwm_and_gate_counter.sv
// Two-channel direction-aware PWM generator and 12-bit universal edge counter.
// Assumes the link core drives the output terminals on the same clock and
// that every pin input is asynchronous to the driving clock.
`timescale 1ns/1ps

// Summary of operation
// - Reference select low: reference tick is driving clock divided by 512.
// - Reference select high: reference tick follows the external reference clock.
// - Direction swap exchanges forward and reverse channel outputs.
// - Polarity invert low: enable drives high; high: enable drives low.
// - Inverted polarity with both runs: no pulses, both enables high.
// - Power and run requests are sampled once per 64 reference clocks.
// - Direction swap and polarity invert act on the outputs immediately.
// - All three mode-select pins high select PWM mode 2.
// - In PWM modes, chain and strobe pins become PWM control inputs.
// - Mode 2 maps PWM to pins 12-15 and counter to link bits 0-11.
// - PWM modes force strobe order low, handshake select high, chain unused.
// - A 12-bit up-counter counts rising edges of the count input.
// - After its maximum the counter wraps to zero and keeps counting.
// - Reset clears the counter and the gate holding register.
// - Two mode pins choose free, internal gate 1, internal gate 2, external gate.
// - Free mode counts while clear is high; low holds counter at zero.
// - Internal gate 1 divides the driving clock by 4,194,304.
// - Gated: count while high, hold on fall, clear on rise.
// - Single run request enables and pulses its channel; both run idle.
// - Period is 64 reference clocks, high for power plus one.
// - Internal gate 2 divides the driving clock by 67,108,864.
// - External gate mode uses the gate pin level as the gate.
module pwm_and_gate_counter
	import pwm_gate_pkg::*;
#(
	parameter int GATE1_LOG2 = GATE1_DIV_LOG2,
	parameter int GATE2_LOG2 = GATE2_DIV_LOG2
) (
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Link core output terminals.
	input wire logic [LINK_W-1:0] i_link_output_bit,
	// Pin inputs.
	input wire logic [LINK_W-1:0] i_ext_pin,
	input wire logic [2:0] i_io_select,
	input wire logic i_strobe_ctl_a_pin,
	input wire logic i_strobe_ctl_b_pin,
	input wire logic i_chain_pin,
	input wire logic i_second_strobe_pin,
	// PWM outputs to pins 12 to 15.
	output logic o_forward_pulse_out,
	output logic o_reverse_pulse_out,
	output logic o_forward_enable_out,
	output logic o_reverse_enable_out,
	// Link core input terminals and pass-through terminals.
	output logic [LINK_W-1:0] o_link_input_bit,
	output logic [3:0] o_aux_output,
	// Mode and strobe control towards the link core.
	output logic o_pwm_mode,
	output logic o_pwm_mode2,
	output logic o_strobe_order_select,
	output logic o_handshake_select,
	output logic o_chain_strobe_disable
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation.

	logic [SYNC_W-1:0] pins_s;

	// All pin inputs cross into the clock domain through three stages.
	pin_sync3 #(
		.WIDTH(SYNC_W)
	) u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_async({i_second_strobe_pin, i_chain_pin, i_strobe_ctl_b_pin,
			i_strobe_ctl_a_pin, i_io_select, i_ext_pin}),
		.o_sync(pins_s)
	);

	logic [2:0] io_select;
	logic pwm_mode;
	logic pwm_mode2;
	logic direction_swap;
	logic ref_clock_select;
	logic enable_polarity_invert;
	logic external_ref_clock;
	logic count_input;
	logic gate_pin;
	count_mode_t count_mode;

	// Pin roles in the PWM modes.
	assign io_select = pins_s[SP_IOSEL+:3];
	assign pwm_mode = io_select[2] & io_select[1];
	assign pwm_mode2 = &io_select;
	assign direction_swap = pins_s[SP_CTL_A];
	assign ref_clock_select = pins_s[SP_CTL_B];
	assign enable_polarity_invert = pins_s[SP_CHAIN];
	assign external_ref_clock = pins_s[SP_SECOND_STROBE_OUT];
	assign count_input = pins_s[SP_PIN0+PIN_COUNT_IN];
	assign gate_pin = pins_s[SP_PIN0+PIN_GATE];
	assign count_mode = count_mode_t'({pins_s[SP_PIN0+PIN_MODE1],
		pins_s[SP_PIN0+PIN_MODE0]});

	// Enable level for one channel under the polarity control.
	function automatic logic enable_level(input logic active, input logic invert);
		enable_level = active ^ invert;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reference clock generation.

	logic [REF_DIV_W-1:0] ref_div_q;
	logic ext_ref_prev_q;
	logic ref_tick;

	// Free-running divider for the internal reference.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			ref_div_q <= '0;
		else
			ref_div_q <= ref_div_q + 1'b1;
	end

	// Previous level of the synchronised external reference.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			ext_ref_prev_q <= 1'b0;
		else
			ext_ref_prev_q <= external_ref_clock;
	end

	// One-cycle reference tick from the selected source.
	always_comb
	begin
		if (ref_clock_select)
			ref_tick = external_ref_clock & ~ext_ref_prev_q;
		else
			ref_tick = (ref_div_q == REF_DIV_LAST);
	end

	////////////////////////////////////////////////////////////////////////
	// PWM period and sampling.

	logic [PWM_PHASE_W-1:0] phase_q;
	logic [PWM_PHASE_W-1:0] power_q;
	logic fwd_run_q;
	logic rev_run_q;

	// Phase counter runs over 64 reference clocks.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			phase_q <= '0;
		else if (ref_tick)
			phase_q <= phase_q + 1'b1;
	end

	// Power and run requests are taken only at the period boundary.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			power_q <= POWER_RESET;
			fwd_run_q <= 1'b0;
			rev_run_q <= 1'b0;
		end
		else if (ref_tick && phase_q == PWM_PHASE_LAST)
		begin
			power_q <= i_link_output_bit[LO_POWER_LSB+:PWM_PHASE_W];
			fwd_run_q <= i_link_output_bit[LO_FWD_RUN];
			rev_run_q <= i_link_output_bit[LO_REV_RUN];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// PWM outputs.

	logic pwm_level;
	logic fwd_only;
	logic rev_only;
	logic fwd_act;
	logic rev_act;

	// High for power plus one reference clocks; 3F stays high.
	assign pwm_level = (phase_q <= power_q);
	// Both requests at once leave both channels idle.
	assign fwd_only = fwd_run_q & ~rev_run_q;
	assign rev_only = rev_run_q & ~fwd_run_q;
	// Swap reacts to the current pin level, not the period boundary.
	assign fwd_act = direction_swap ? rev_only : fwd_only;
	assign rev_act = direction_swap ? fwd_only : rev_only;

	// Pulse and enable outputs; idle low outside the PWM modes.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			o_forward_pulse_out <= 1'b0;
			o_reverse_pulse_out <= 1'b0;
			o_forward_enable_out <= 1'b0;
			o_reverse_enable_out <= 1'b0;
		end
		else
		begin
			o_forward_pulse_out <= pwm_mode & fwd_act & pwm_level;
			o_reverse_pulse_out <= pwm_mode & rev_act & pwm_level;
			o_forward_enable_out <= pwm_mode &
				enable_level(fwd_act, enable_polarity_invert);
			o_reverse_enable_out <= pwm_mode &
				enable_level(rev_act, enable_polarity_invert);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Gate generation.

	logic [GATE_DIV_W-1:0] gate_div_q;
	logic gate;
	logic gate_prev_q;
	logic count_prev_q;
	logic count_rise;

	// Free-running gate divider; bit n-1 is the clock divided by 2^n.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			gate_div_q <= '0;
		else
			gate_div_q <= gate_div_q + 1'b1;
	end

	// Gate source per counting mode.
	always_comb
	begin
		case (count_mode)
			CM_GATE1: gate = gate_div_q[GATE1_LOG2-1];
			CM_GATE2: gate = gate_div_q[GATE2_LOG2-1];
			CM_EXT_GATE: gate = gate_pin;
			default: gate = gate_pin;
		endcase
	end

	// Edge history of the gate and the count input.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			gate_prev_q <= 1'b0;
			count_prev_q <= 1'b0;
		end
		else
		begin
			gate_prev_q <= gate;
			count_prev_q <= count_input;
		end
	end

	assign count_rise = count_input & ~count_prev_q;

	////////////////////////////////////////////////////////////////////////
	// Universal counter.

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] hold_q;

	// Count, clear and wrap behaviour in every mode.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			count_q <= CNT_RESET;
		else if (count_mode == CM_FREE)
		begin
			if (!gate)
				count_q <= CNT_RESET;
			else if (count_rise)
				count_q <= count_q + CNT_ONE;
		end
		else if (gate && !gate_prev_q)
			count_q <= CNT_RESET;
		else if (gate && count_rise)
			count_q <= count_q + CNT_ONE;
	end

	// Holding register takes the count on the gate's falling edge outside free mode.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			hold_q <= CNT_RESET;
		else if (count_mode != CM_FREE && !gate && gate_prev_q)
			hold_q <= count_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Link terminals and mode control.

	// Counter value on bits 0-11, pins 0-3 on bits 12-15 in mode 2.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
			o_link_input_bit <= '0;
		else if (pwm_mode2)
			o_link_input_bit <= {pins_s[SP_PIN0+:4],
				(count_mode == CM_FREE) ? count_q : hold_q};
		else
			o_link_input_bit <= '0;
	end

	// Output terminals 8-11 pass straight on; mode and strobe overrides.
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_reset_n)
		begin
			o_aux_output <= '0;
			o_pwm_mode <= 1'b0;
			o_pwm_mode2 <= 1'b0;
			o_strobe_order_select <= 1'b0;
			o_handshake_select <= 1'b0;
			o_chain_strobe_disable <= 1'b0;
		end
		else
		begin
			o_aux_output <= i_link_output_bit[LO_AUX_LSB+:4];
			o_pwm_mode <= pwm_mode;
			o_pwm_mode2 <= pwm_mode2;
			o_strobe_order_select <= pwm_mode ? 1'b0 : pins_s[SP_CTL_A];
			o_handshake_select <= pwm_mode ? 1'b1 : pins_s[SP_CTL_B];
			o_chain_strobe_disable <= pwm_mode;
		end
	end

endmodule

// file: tb/pwm_gate_chk.sv
// Checker for the PWM generator and edge counter, watching top ports only.
// Assumes a bind to pwm_and_gate_counter and one clock domain.
`timescale 1ns/1ps

module pwm_gate_chk
	import pwm_gate_pkg::*;
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	// Watched inputs.
	input wire logic [LINK_W-1:0] i_link_output_bit,
	input wire logic [LINK_W-1:0] i_ext_pin,
	input wire logic [2:0] i_io_select,
	input wire logic i_strobe_ctl_a_pin,
	input wire logic i_strobe_ctl_b_pin,
	input wire logic i_chain_pin,
	// Watched outputs.
	input wire logic o_forward_pulse_out,
	input wire logic o_reverse_pulse_out,
	input wire logic o_forward_enable_out,
	input wire logic o_reverse_enable_out,
	input wire logic [LINK_W-1:0] o_link_input_bit,
	input wire logic [3:0] o_aux_output,
	input wire logic o_pwm_mode,
	input wire logic o_pwm_mode2,
	input wire logic o_strobe_order_select,
	input wire logic o_handshake_select,
	input wire logic o_chain_strobe_disable
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	wire logic [11:0] ctl_w = {i_ext_pin[7:6], i_ext_pin[3:0], i_io_select,
		i_strobe_ctl_a_pin, i_strobe_ctl_b_pin, i_chain_pin};
	logic [11:0] ctl_q;
	logic [19:0] quiet_q;
	logic [19:0] gap_q;
	logic fwd_q;
	//////////////////////////////////////////////////////////////////////
	// Counts cycles with control pins unchanged, and cycles since a forward pulse edge.
	always_ff @(posedge i_sys_clk)
	begin
		ctl_q <= ctl_w;
		fwd_q <= o_forward_pulse_out;
		if (!i_reset_n || ctl_w != ctl_q)
			quiet_q <= '0;
		else if (quiet_q != 20'hFFFFF)
			quiet_q <= quiet_q + 20'h00001;
		if (!i_reset_n || fwd_q != o_forward_pulse_out)
			gap_q <= '0;
		else if (gap_q != 20'hFFFFF)
			gap_q <= gap_q + 20'h00001;
	end
	//////////////////////////////////////////////////////////////////////
	// Output relations.
	a_pulses_exclusive: assert property (!(o_forward_pulse_out && o_reverse_pulse_out))
		else $error("both pulse outputs high");
	a_pulse_enables: assert property (o_forward_pulse_out || o_reverse_pulse_out |->
		o_forward_enable_out != o_reverse_enable_out) else $error("enables equal while pulsing");
	a_pwm_strobe: assert property (o_pwm_mode |-> !o_strobe_order_select &&
		o_handshake_select && o_chain_strobe_disable) else $error("strobe controls not forced");
	a_mode2_pwm: assert property (o_pwm_mode2 |-> o_pwm_mode)
		else $error("mode 2 without pwm mode");
	a_idle_outside: assert property (!o_pwm_mode |-> !o_forward_pulse_out &&
		!o_reverse_pulse_out && !o_forward_enable_out && !o_reverse_enable_out)
		else $error("pwm outputs active outside pwm modes");
	a_link_zero: assert property (!o_pwm_mode2 |-> o_link_input_bit == 16'h0000)
		else $error("link bits nonzero outside mode 2");
	a_aux_copy: assert property ($past(i_reset_n) |->
		o_aux_output == $past(i_link_output_bit[11:8])) else $error("aux terminals wrong");
	a_pins_pass: assert property (o_pwm_mode2 && $past(o_pwm_mode2) && quiet_q > 20'h00008 |->
		o_link_input_bit[15:12] == i_ext_pin[3:0]) else $error("pins 0-3 not on link 12-15");
	a_free_step: assert property (o_pwm_mode2 && i_ext_pin[7:6] == 2'h0 && quiet_q > 20'h00008 &&
		$changed(o_link_input_bit[11:0]) |-> o_link_input_bit[11:0] == CNT_RESET ||
		o_link_input_bit[11:0] == $past(o_link_input_bit[11:0]) + CNT_ONE)
		else $error("free count did not step by one");
	a_ref_512: assert property (fwd_q != o_forward_pulse_out && !i_strobe_ctl_b_pin &&
		quiet_q > gap_q + 20'h00010 |-> gap_q[8:0] == 9'h1FF) else $error("pulse edge off 512 grid");
endmodule

// file: tb/pin_source_model.sv
// Far-side pin sources: a pulse source on the count input and an external reference.
// Assumes the bench calls send_pulses and drives i_ref_run as a level.
`timescale 1ns/1ps

module pin_source_model (
	// Reference request.
	input wire logic i_ref_run,
	// Pin levels towards the block.
	output logic o_count_in,
	output logic o_ext_ref
);
	// Each level lasts 128 ns, longer than 1.5 bit periods at the fastest rate.
	task automatic send_pulses(input int n);
		repeat (n)
		begin
			o_count_in = 1'b1;
			#128;
			o_count_in = 1'b0;
			#128;
		end
	endtask
	// A 25 MHz reference with 20 ns phases, held low and steady when not asked for.
	initial
	begin
		o_count_in = 1'b0;
		o_ext_ref = 1'b0;
		#3;
		forever
		begin
			#20;
			o_ext_ref = i_ref_run ? ~o_ext_ref : 1'b0;
		end
	end
endmodule

// file: tb/pwm_and_gate_counter_tb.sv
// Self-checking bench for the PWM generator and universal counter.
// Assumes shortened gate dividers of 2^12 and 2^13 driving clocks.
`timescale 1ns/1ps

module pwm_and_gate_counter_tb;
	logic sys_clk, rst_n, swap, refsel, inv, ref_run, gate, cnt, extref;
	logic [15:0] lo;
	logic [3:0] pins;
	logic [7:0] hi_pins;
	logic [1:0] mode;
	logic [2:0] iosel;
	logic fp, rp, fe, re, pm, pm2, so, hs, dis;
	logic [15:0] li;
	logic [3:0] aux;
	int fails = 0;
	int n_compared = 0;
	wire logic [3:0] outs = {fp, rp, fe, re};
	pwm_and_gate_counter #(.GATE1_LOG2(12), .GATE2_LOG2(13)) DUT (.i_sys_clk(sys_clk),
		.i_reset_n(rst_n), .i_link_output_bit(lo), .i_ext_pin({hi_pins, mode, gate, cnt, pins}),
		.i_io_select(iosel), .i_strobe_ctl_a_pin(swap), .i_strobe_ctl_b_pin(refsel),
		.i_chain_pin(inv), .i_second_strobe_pin(extref), .o_forward_pulse_out(fp),
		.o_reverse_pulse_out(rp), .o_forward_enable_out(fe), .o_reverse_enable_out(re),
		.o_link_input_bit(li), .o_aux_output(aux), .o_pwm_mode(pm), .o_pwm_mode2(pm2),
		.o_strobe_order_select(so), .o_handshake_select(hs), .o_chain_strobe_disable(dis));
	pin_source_model src (.i_ref_run(ref_run), .o_count_in(cnt), .o_ext_ref(extref));
	// Clock of 4 ns period.
	always #2 sys_clk = ~sys_clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Waits for the forward pulse to reach a level, giving up after 40000 cycles.
	task automatic wait_level(input logic v);
		int k;
		k = 0;
		while (fp !== v && k < 40000)
		begin
			cyc(1);
			k++;
		end
		// A level that never arrives counts as a mismatch.
		if (k >= 40000)
			fails++;
	endtask
	task automatic count_level(input logic v, output int n);
		n = 0;
		while (fp === v && n < 40000)
		begin
			n++;
			cyc(1);
		end
	endtask
	task automatic summarize();
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		int n;
		{sys_clk, rst_n, refsel, inv, ref_run, gate, mode, iosel} = '0;
		{lo, pins, hi_pins} = '0;
		swap = 1'b1;
		cyc(10);
		rst_n = 1'b1;
		cyc(8);
		chk(li, 16'h0000);
		chk(16'({so, hs, dis}), 16'h0004);
		{swap, gate, pins, lo, iosel} = {1'b0, 1'b1, 4'h9, 16'h0A00, 3'h6};
		cyc(8);
		chk(16'({pm, pm2}), 16'h0002);
		chk(li, 16'h0000);
		chk(16'(aux), 16'h000A);
		chk(16'({so, hs, dis}), 16'h0003);
		// Pins 12-15 carry PWM outputs and pins 8-11 are unused, so their input levels must never reach the link.
		{iosel, hi_pins} = {3'h7, 8'hC3};
		cyc(8);
		chk(16'({pm, pm2}), 16'h0003);
		chk(li, 16'h9000);
		src.send_pulses(5);
		cyc(8);
		chk(16'(li[11:0]), 16'h0005);
		gate = 1'b0;
		cyc(8);
		src.send_pulses(2);
		cyc(8);
		chk(16'(li[11:0]), 16'h0000);
		gate = 1'b1;
		cyc(8);
		src.send_pulses(3);
		cyc(8);
		chk(16'(li[11:0]), 16'h0003);
		gate = 1'b0;
		mode = 2'h3;
		cyc(8);
		gate = 1'b1;
		cyc(8);
		src.send_pulses(4);
		gate = 1'b0;
		cyc(8);
		chk(16'(li[11:0]), 16'h0004);
		gate = 1'b1;
		cyc(8);
		src.send_pulses(2);
		cyc(8);
		chk(16'(li[11:0]), 16'h0004);
		gate = 1'b0;
		cyc(8);
		chk(16'(li[11:0]), 16'h0002);
		mode = 2'h1;
		src.send_pulses(140);
		chk(16'(li[11:0] >= 12'h01F && li[11:0] <= 12'h021), 16'h0001);
		mode = 2'h2;
		src.send_pulses(280);
		chk(16'(li[11:0] >= 12'h03F && li[11:0] <= 12'h041), 16'h0001);
		lo = 16'h0A41;
		wait_level(1'b1);
		chk(16'(outs), 16'h000A);
		lo = 16'h0A45;
		count_level(1'b1, n);
		chk(16'(n), 16'h0400);
		{refsel, ref_run} = 2'h3;
		wait_level(1'b0);
		wait_level(1'b1);
		count_level(1'b1, n);
		chk(16'(n), 16'h003C);
		lo = 16'h0A7F;
		cyc(700);
		n = 0;
		repeat (700)
		begin
			n += (fp !== 1'b1);
			cyc(1);
		end
		chk(16'(n), 16'h0000);
		// Swap changes only while the pulse stands constantly high, so no pulse is cut.
		swap = 1'b1;
		cyc(8);
		chk(16'(outs), 16'h0005);
		inv = 1'b1;
		cyc(8);
		chk(16'(outs), 16'h0006);
		lo = 16'h0AFF;
		cyc(700);
		chk(16'(outs), 16'h0003);
		inv = 1'b0;
		cyc(8);
		chk(16'(outs), 16'h0000);
		{swap, lo} = {1'b0, 16'h0ABF};
		cyc(700);
		chk(16'(outs), 16'h0005);
		summarize();
	end
	// Watchdog well beyond the expected run length.
	initial
	begin
		#300000;
		fails++;
		summarize();
	end
endmodule

bind pwm_and_gate_counter pwm_gate_chk chk (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
	.i_link_output_bit(i_link_output_bit), .i_ext_pin(i_ext_pin), .i_io_select(i_io_select),
	.i_strobe_ctl_a_pin(i_strobe_ctl_a_pin), .i_strobe_ctl_b_pin(i_strobe_ctl_b_pin),
	.i_chain_pin(i_chain_pin), .o_forward_pulse_out(o_forward_pulse_out),
	.o_reverse_pulse_out(o_reverse_pulse_out), .o_forward_enable_out(o_forward_enable_out),
	.o_reverse_enable_out(o_reverse_enable_out), .o_link_input_bit(o_link_input_bit),
	.o_aux_output(o_aux_output), .o_pwm_mode(o_pwm_mode), .o_pwm_mode2(o_pwm_mode2),
	.o_strobe_order_select(o_strobe_order_select), .o_handshake_select(o_handshake_select),
	.o_chain_strobe_disable(o_chain_strobe_disable));
